// [frame_cmd_map.svh]
// Constants of the framed command engine: codes, byte values, sizes.
// Included by the engine; holds definitions only.
`ifndef FRAME_CMD_MAP_SVH
`define FRAME_CMD_MAP_SVH
// ---------------------------------------------------------------
// Frame bytes
// ---------------------------------------------------------------
`define LEAD_BYTE        8'hA5
`define ACK_BYTE         8'h06
`define NAK_BYTE         8'h15
`define CHECKSUM_ERROR_REPLY 8'h51
`define STREAM_LEAD_BYTE_FIRST  8'hAB
`define STREAM_LEAD_BYTE_SECOND 8'hCD
`define STREAM_LEAD_BYTE_THIRD  8'hEF
// ---------------------------------------------------------------
// Command codes
// ---------------------------------------------------------------
`define CMD_RD16   8'h52
`define CMD_RD32   8'h44
`define CMD_WR16   8'h57
`define CMD_WR32   8'h45
`define CMD_RDN    8'h4E
`define CMD_WRN    8'h4D
`define CMD_SEL    8'h4C
`define CMD_DESEL  8'h4B
`define CMD_PTR    8'h41
`define CMD_SAVE   8'h53
`define CMD_PGRD   8'h42
`define CMD_PGWR   8'h50
`define CMD_ERASE  8'h4F
`define CMD_CALG   8'h5A
`define CMD_CALF   8'h76
// ---------------------------------------------------------------
// Sizes and limits
// ---------------------------------------------------------------
`define FRAME_DEPTH  128
`define FRAME_MIN    8'h04
`define RESP_DEPTH   64
`define READ_MAX     7'h30
`define WRITE_MAX    8'h40
`define PAGE_LEN     7'h10
`define STREAM_LEN   7'h10
`define PTR_MAX      16'h00FF
`endif

// [frame_cmd_pkg.sv]
// Types shared by the framed command engine.
// Pure type definitions; no logic.
package frame_cmd_pkg;
   typedef enum logic [3:0] {
      S_IDLE, S_RXC, S_RXB, S_EXEC, S_XA, S_XW, S_XC, S_TX, S_AUTO
   } state_e;
endpackage : frame_cmd_pkg

// [byte_skid2.sv]
// Two-entry buffer with valid/ready on both sides.
// Same clock on both sides; outputs come from flip-flops.
`timescale 1ns/1ps
module byte_skid2 (
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   input  wire logic       in_valid_i,
   input  wire logic [7:0] in_data_i,
   output logic            in_ready_o,
   output logic            out_valid_o,
   output logic [7:0]      out_data_o,
   input  wire logic       out_ready_i
);
   logic [7:0] head_q, head_d, tail_q, tail_d;
   logic       hv_q, hv_d, tv_q, tv_d;
   logic       push, pop;

   // ---------------------------------------------------------------
   // Next state; tail entry absorbs one word while head stalls
   // ---------------------------------------------------------------
   always_comb begin
      push   = in_valid_i && !tv_q;
      pop    = hv_q && out_ready_i;
      head_d = head_q;
      tail_d = tail_q;
      hv_d   = hv_q;
      tv_d   = tv_q;
      if (pop) begin
         if (tv_q) begin
            head_d = tail_q;
            tv_d   = 1'b0;
         end else begin
            head_d = in_data_i;
            hv_d   = push;
         end
      end else if (push) begin
         if (!hv_q) begin
            head_d = in_data_i;
            hv_d   = 1'b1;
         end else begin
            tail_d = in_data_i;
            tv_d   = 1'b1;
         end
      end
   end

   // Registers
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         head_q <= 8'h00;
         tail_q <= 8'h00;
         hv_q   <= 1'b0;
         tv_q   <= 1'b0;
      end else begin
         head_q <= head_d;
         tail_q <= tail_d;
         hv_q   <= hv_d;
         tv_q   <= tv_d;
      end
   end

   assign in_ready_o  = !tv_q;   // Full only when both entries hold
   assign out_valid_o = hv_q;
   assign out_data_o  = head_q;
endmodule : byte_skid2

// [framed_uart_command_engine.sv]
// Framed command interpreter behind the byte-level UART link.
// Assumes a byte receiver and transmitter on clk_i, a byte-wide register/EEPROM
// port whose read data is valid one cycle after mem_rd_o, and an async mode pin.
`timescale 1ns/1ps
`include "frame_cmd_map.svh"
module framed_uart_command_engine
   import frame_cmd_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   input  wire logic        rx_valid_i,
   input  wire logic [7:0]  rx_data_i,
   output logic             rx_ready_o,
   output logic             tx_valid_o,
   output logic [7:0]       tx_data_o,
   input  wire logic        tx_ready_i,
   output logic [15:0]      mem_addr_o,
   output logic [7:0]       mem_wdata_o,
   output logic             mem_rd_o,
   output logic             mem_wr_o,
   output logic             mem_ee_o,
   input  wire logic [7:0]  mem_rdata_i,
   input  wire logic [7:0]  dev_addr_i,
   input  wire logic        multi_mode_i,
   input  wire logic        single_wire_i,
   input  wire logic        cycle_done_i,
   input  wire logic [31:0] irms_i,
   input  wire logic [15:0] vrms_i,
   input  wire logic [31:0] pact_i,
   input  wire logic [15:0] freq_i,
   output logic             dir_o,
   output logic             save_o,
   output logic             erase_o,
   output logic             cal_gain_o,
   output logic             cal_freq_o
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   state_e      st_q, st_d;
   logic [7:0]  fb [`FRAME_DEPTH];
   logic [7:0]  resp [`RESP_DEPTH];
   logic [7:0]  fcnt_q, fcnt_d, fi_q, fi_d, ci_q, ci_d, sum_q, sum_d, code_q, code_d;
   logic [15:0] ptr_q, ptr_d, base_q, base_d, addr_q, addr_d;
   logic [6:0]  rlen_q, rlen_d, len_q, len_d, k_q, k_d, ti_q, ti_d;
   logic [7:0]  src_q, src_d, wdat_q, wdat_d;
   logic        ee_q, ee_d, wr_q, wr_d, rev_q, rev_d, mrd_q, mrd_d, mwr_q, mwr_d;
   logic        dir_q, dir_d, swp_q, swp_d, rdy_q, rdy_d, m1_q, m2_q;
   logic        save_q, save_d, erase_q, erase_d, calg_q, calg_d, calf_q, calf_d;
   logic [95:0] snap_q, snap_d;
   logic        fb_we, rs_we, rxhs, push, s_ready;
   logic [6:0]  fb_wa;
   logic [5:0]  rs_wa;
   logic [7:0]  pbyte, cmd, p1, p2, plen;
   logic [8:0]  end_i;

   // Packet length per command; 0 marks an unknown code
   function automatic logic [7:0] pkt_len(input logic [7:0] c, input logic [7:0] n);
      unique case (c)
         `CMD_RD16, `CMD_RD32: pkt_len = 8'd1;
         `CMD_WR16, `CMD_PTR: pkt_len = 8'd3;
         `CMD_WR32: pkt_len = 8'd5;
         `CMD_WRN: pkt_len = 8'(n + 8'd2);
         `CMD_PGWR: pkt_len = 8'd18;
         `CMD_RDN, `CMD_SEL, `CMD_DESEL, `CMD_SAVE, `CMD_PGRD,
         `CMD_ERASE, `CMD_CALG, `CMD_CALF: pkt_len = 8'd2;
         default: pkt_len = 8'd0;
      endcase
   endfunction : pkt_len

   // ---------------------------------------------------------------
   // Mode pin synchroniser
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         m1_q <= 1'b0;
         m2_q <= 1'b0;
      end else begin
         m1_q <= multi_mode_i;
         m2_q <= m1_q;
      end
   end

   assign rxhs  = rx_valid_i && rdy_q;
   assign cmd   = fb[ci_q[6:0]];
   assign p1    = fb[7'(ci_q + 8'd1)];
   assign p2    = fb[7'(ci_q + 8'd2)];
   assign plen  = pkt_len(cmd, p1);
   assign end_i = {1'b0, ci_q} + {1'b0, plen};

   // Outgoing byte for reply and stream frames
   always_comb begin
      pbyte = sum_q;
      if (st_q == S_AUTO) begin
         unique case (ti_q)
            7'd0: pbyte = `STREAM_LEAD_BYTE_FIRST;
            7'd1: pbyte = `STREAM_LEAD_BYTE_SECOND;
            7'd2: pbyte = `STREAM_LEAD_BYTE_THIRD;
            7'd15: pbyte = sum_q;
            default: pbyte = snap_q[8*(ti_q-7'd3) +: 8];
         endcase
      end else if (code_q != `ACK_BYTE || rlen_q == 7'd0) begin
         pbyte = code_q;
      end else if (ti_q == 7'd0) begin
         pbyte = `ACK_BYTE;
      end else if (ti_q == 7'd1) begin
         pbyte = {1'b0, 7'(rlen_q + 7'd3)};
      end else if (ti_q < 7'(rlen_q + 7'd2)) begin
         pbyte = resp[6'(ti_q - 7'd2)];
      end
   end

   assign push = (st_q == S_TX || st_q == S_AUTO) && s_ready;

   // ---------------------------------------------------------------
   // Main sequencer
   // ---------------------------------------------------------------
   always_comb begin
      st_d = st_q; fcnt_d = fcnt_q; fi_d = fi_q; ci_d = ci_q; sum_d = sum_q;
      code_d = code_q; ptr_d = ptr_q; base_d = base_q; addr_d = addr_q;
      rlen_d = rlen_q; len_d = len_q; k_d = k_q; ti_d = ti_q; src_d = src_q;
      wdat_d = wdat_q; ee_d = ee_q; wr_d = wr_q; rev_d = rev_q; dir_d = dir_q;
      snap_d = snap_q;
      mrd_d = 1'b0; mwr_d = 1'b0; save_d = 1'b0; erase_d = 1'b0;
      calg_d = 1'b0; calf_d = 1'b0;
      fb_we = 1'b0; fb_wa = fi_q[6:0]; rs_we = 1'b0; rs_wa = rlen_q[5:0];
      // Event is kept pending while busy; a new event beats the clear
      swp_d = swp_q || (single_wire_i && cycle_done_i);
      unique case (st_q)
         S_IDLE: begin
            if (rxhs) begin
               if (rx_data_i == `LEAD_BYTE) begin
                  fb_we = 1'b1; fb_wa = 7'd0;
                  sum_d = rx_data_i;
                  fi_d  = 8'd1;
                  st_d  = S_RXC;
               end
            end else if (swp_q) begin
               swp_d  = single_wire_i && cycle_done_i;
               snap_d = {freq_i, pact_i, vrms_i, irms_i};
               sum_d  = 8'h00; ti_d = 7'd0;
               st_d   = S_AUTO;
            end
         end
         S_RXC: if (rxhs) begin
            fb_we = 1'b1; fb_wa = 7'd1;
            fcnt_d = rx_data_i;
            sum_d  = 8'(sum_q + rx_data_i);
            fi_d   = 8'd2;
            ti_d   = 7'd0;
            if (rx_data_i < `FRAME_MIN || rx_data_i > 8'(`FRAME_DEPTH)) begin
               code_d = `NAK_BYTE;
               st_d   = S_TX;
            end else begin
               st_d = S_RXB;
            end
         end
         S_RXB: if (rxhs) begin
            fb_we = 1'b1;
            if (fi_q == 8'(fcnt_q - 8'd1)) begin
               rlen_d = 7'd0; ci_d = 8'd2;
               if (rx_data_i == sum_q) begin
                  code_d = `ACK_BYTE;
                  st_d   = S_EXEC;
               end else begin
                  code_d = `CHECKSUM_ERROR_REPLY;
                  st_d   = S_TX;
               end
            end else begin
               sum_d = 8'(sum_q + rx_data_i);
               fi_d  = 8'(fi_q + 8'd1);
            end
         end
         S_EXEC: begin
            k_d = 7'd0; src_d = 8'(ci_q + 8'd1); rev_d = 1'b0; ee_d = 1'b0;
            wr_d = 1'b0; base_d = ptr_q; ci_d = end_i[7:0];
            if (ci_q == 8'(fcnt_q - 8'd1)) begin
               sum_d = 8'h00;
               st_d  = S_TX;
            end else if (plen == 8'd0 || end_i > {1'b0, 8'(fcnt_q - 8'd1)}) begin
               code_d = `NAK_BYTE;
               st_d   = S_TX;
            end else begin
               unique case (cmd)
                  `CMD_RD16, `CMD_RD32: begin
                     len_d = (cmd == `CMD_RD16) ? 7'd2 : 7'd4;
                     rev_d = 1'b1;
                     st_d  = S_XA;
                  end
                  `CMD_RDN: begin
                     len_d = p1[6:0];
                     st_d  = S_XA;
                  end
                  `CMD_WR16, `CMD_WR32: begin
                     len_d = (cmd == `CMD_WR16) ? 7'd2 : 7'd4;
                     rev_d = 1'b1; wr_d = 1'b1;
                     st_d  = S_XA;
                  end
                  `CMD_WRN: begin
                     len_d = p1[6:0];
                     src_d = 8'(ci_q + 8'd2);
                     wr_d  = 1'b1;
                     st_d  = (p1 > `WRITE_MAX) ? S_TX : S_XA;
                  end
                  `CMD_PGRD, `CMD_PGWR: begin
                     len_d  = `PAGE_LEN;
                     base_d = {4'h0, p1, 4'h0};
                     src_d  = 8'(ci_q + 8'd2);
                     ee_d   = 1'b1; wr_d = (cmd == `CMD_PGWR);
                     st_d   = S_XA;
                  end
                  `CMD_PTR: if ({p1, p2} <= `PTR_MAX) ptr_d = {p1, p2};
                  else st_d = S_TX;
                  default: if (p1 != dev_addr_i) st_d = S_TX;
                  else begin
                     if (cmd == `CMD_SEL && m2_q) dir_d = 1'b1;
                     if (cmd == `CMD_DESEL && m2_q) dir_d = 1'b0;
                     save_d  = (cmd == `CMD_SAVE);
                     erase_d = (cmd == `CMD_ERASE);
                     calg_d  = (cmd == `CMD_CALG);
                     calf_d  = (cmd == `CMD_CALF);
                  end
               endcase
               // Reply space bounds the reads of one frame
               if (!wr_d && st_d == S_XA && 8'(rlen_q) + 8'(len_d) > 8'(`RESP_DEPTH))
                  st_d = S_TX;
               if (cmd == `CMD_RDN && 8'(rlen_q) + p1 > 8'(`READ_MAX))
                  st_d = S_TX;
               if (st_d == S_TX) begin
                  code_d = `NAK_BYTE;
                  sum_d  = 8'h00;
               end
            end
            ti_d = 7'd0;
         end
         S_XA: begin
            addr_d = rev_q ? 16'(base_q + 16'(len_q) - 16'd1 - 16'(k_q)) : 16'(base_q + 16'(k_q));
            wdat_d = fb[7'(src_q + 8'(k_q))];
            mrd_d  = !wr_q;
            mwr_d  = wr_q;
            st_d   = (len_q == 7'd0) ? S_EXEC : S_XW;
         end
         S_XW: st_d = S_XC;
         S_XC: begin
            rs_we  = !wr_q;
            rlen_d = wr_q ? rlen_q : 7'(rlen_q + 7'd1);
            k_d    = 7'(k_q + 7'd1);
            st_d   = (7'(k_q + 7'd1) == len_q) ? S_EXEC : S_XA;
         end
         S_TX: if (push) begin
            sum_d = 8'(sum_q + pbyte);
            ti_d  = 7'(ti_q + 7'd1);
            if (code_q != `ACK_BYTE || rlen_q == 7'd0 || ti_q == 7'(rlen_q + 7'd2))
               st_d = S_IDLE;
         end
         S_AUTO: if (push) begin
            sum_d = 8'(sum_q + pbyte);
            ti_d  = 7'(ti_q + 7'd1);
            if (ti_q == 7'(`STREAM_LEN - 7'd1)) st_d = S_IDLE;
         end
      endcase
      ee_d  = (st_d == S_XA || st_d == S_XW || st_d == S_XC) ? ee_d : 1'b0;
      rdy_d = (st_d == S_IDLE || st_d == S_RXC || st_d == S_RXB);
   end

   // Registers of the sequencer
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_q <= S_IDLE; fcnt_q <= 8'h00; fi_q <= 8'h00; ci_q <= 8'h00;
         sum_q <= 8'h00; code_q <= 8'h00; ptr_q <= 16'h0000; base_q <= 16'h0000;
         addr_q <= 16'h0000; rlen_q <= 7'h00; len_q <= 7'h00; k_q <= 7'h00;
         ti_q <= 7'h00; src_q <= 8'h00; wdat_q <= 8'h00; ee_q <= 1'b0;
         wr_q <= 1'b0; rev_q <= 1'b0; mrd_q <= 1'b0; mwr_q <= 1'b0;
         dir_q <= 1'b0; swp_q <= 1'b0; rdy_q <= 1'b0; snap_q <= 96'h0;
         save_q <= 1'b0; erase_q <= 1'b0; calg_q <= 1'b0; calf_q <= 1'b0;
      end else begin
         st_q <= st_d; fcnt_q <= fcnt_d; fi_q <= fi_d; ci_q <= ci_d;
         sum_q <= sum_d; code_q <= code_d; ptr_q <= ptr_d; base_q <= base_d;
         addr_q <= addr_d; rlen_q <= rlen_d; len_q <= len_d; k_q <= k_d;
         ti_q <= ti_d; src_q <= src_d; wdat_q <= wdat_d; ee_q <= ee_d;
         wr_q <= wr_d; rev_q <= rev_d; mrd_q <= mrd_d; mwr_q <= mwr_d;
         dir_q <= dir_d; swp_q <= swp_d; rdy_q <= rdy_d; snap_q <= snap_d;
         save_q <= save_d; erase_q <= erase_d; calg_q <= calg_d; calf_q <= calf_d;
      end
   end

   // Frame and reply stores; no reset, contents are rewritten per frame
   always_ff @(posedge clk_i) begin
      if (fb_we) fb[fb_wa] <= rx_data_i;
      if (rs_we) resp[rs_wa] <= mem_rdata_i;
   end

   // ---------------------------------------------------------------
   // Transmit buffer; a stalled transmitter holds the sequencer
   // ---------------------------------------------------------------
   byte_skid2 u_txbuf (
      .clk_i       (clk_i),
      .nrst_i      (nrst_i),
      .in_valid_i  (st_q == S_TX || st_q == S_AUTO),
      .in_data_i   (pbyte),
      .in_ready_o  (s_ready),
      .out_valid_o (tx_valid_o),
      .out_data_o  (tx_data_o),
      .out_ready_i (tx_ready_i)
   );

   assign rx_ready_o  = rdy_q;
   assign mem_addr_o  = addr_q;
   assign mem_wdata_o = wdat_q;
   assign mem_rd_o    = mrd_q;
   assign mem_wr_o    = mwr_q;
   assign mem_ee_o    = ee_q;
   assign dir_o       = dir_q;
   assign save_o      = save_q;
   assign erase_o     = erase_q;
   assign cal_gain_o  = calg_q;
   assign cal_freq_o  = calf_q;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   property p_rd_capture;
      @(posedge clk_i) disable iff (!nrst_i) mem_rd_o |=> st_q == S_XC ##1 rlen_q == $past(rlen_q) + 7'd1;
   endproperty
   a_rd_capture: assert property (p_rd_capture) else $error("read byte not captured");
   property p_dir_single;
      @(posedge clk_i) disable iff (!nrst_i) !m2_q |=> $stable(dir_o);
   endproperty
   a_dir_single: assert property (p_dir_single) else $error("dir moved in single mode");
   property p_checksum_error;
      @(posedge clk_i) disable iff (!nrst_i)
         st_q == S_RXB && rxhs && fi_q == 8'(fcnt_q - 8'd1) && rx_data_i != sum_q
         |=> st_q == S_TX && code_q == `CHECKSUM_ERROR_REPLY && !mem_wr_o;
   endproperty
   a_checksum_error: assert property (p_checksum_error) else $error("bad checksum not refused");
   property p_no_early_exec;
      @(posedge clk_i) disable iff (!nrst_i)
         (st_q == S_RXB) |-> !mem_wr_o && !save_o && !erase_o && !cal_gain_o;
   endproperty
   a_no_early_exec: assert property (p_no_early_exec) else $error("command ran before check");
   property p_stream_lead;
      @(posedge clk_i) disable iff (!nrst_i)
         st_q == S_AUTO && ti_q == 7'd0 && push |-> pbyte == `STREAM_LEAD_BYTE_FIRST && sum_q == 8'h00;
   endproperty
   a_stream_lead: assert property (p_stream_lead) else $error("stream lead wrong");
   property p_stream_start;
      @(posedge clk_i) disable iff (!nrst_i) st_q == S_IDLE && swp_q && !rxhs |=> st_q == S_AUTO;
   endproperty
   a_stream_start: assert property (p_stream_start) else $error("stream not started");
   property p_ptr_range;
      @(posedge clk_i) disable iff (!nrst_i) ptr_q <= `PTR_MAX;
   endproperty
   a_ptr_range: assert property (p_ptr_range) else $error("pointer out of range");
   property p_ack_lead;
      @(posedge clk_i) disable iff (!nrst_i)
         st_q == S_TX && ti_q == 7'd0 && code_q == `ACK_BYTE |-> pbyte == `ACK_BYTE && sum_q == 8'h00;
   endproperty
   a_ack_lead: assert property (p_ack_lead) else $error("reply lead not ack");
   property p_save_pulse;
      @(posedge clk_i) disable iff (!nrst_i) save_o |=> !save_o ##1 !save_o;
   endproperty
   a_save_pulse: assert property (p_save_pulse) else $error("save not one pulse");
   c_stream: cover property (@(posedge clk_i) disable iff (!nrst_i) st_q == S_AUTO && ti_q == 7'd15 && push);
   c_data_reply: cover property (@(posedge clk_i) disable iff (!nrst_i) st_q == S_TX && rlen_q > 7'd2 && push);
   c_stall: cover property (@(posedge clk_i) disable iff (!nrst_i) st_q == S_TX && !s_ready);
endmodule : framed_uart_command_engine

// [mem_model.sv]
// Byte-wide register and EEPROM store answering the engine's memory port.
// Assumes one shared clock; read data is due the cycle after the strobe.
`timescale 1ns/1ps
module mem_model (
   input  wire logic        clk_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        rd_i,
   input  wire logic        wr_i,
   input  wire logic        ee_i,
   output logic [7:0]       rdata_o
);
   logic [7:0] reg_q [0:255];
   logic [7:0] ee_q  [0:511];
   // Known fill so reads can be predicted from the address alone
   initial begin
      foreach (reg_q[i]) reg_q[i] = 8'(i * 3 + 1);
      foreach (ee_q[i]) ee_q[i] = 8'(i) ^ 8'h5A;
      rdata_o = 8'h00;
   end
   // Outside a read slot the data toggles, so a late capture shows up
   always @(posedge clk_i) begin
      if (wr_i && ee_i) ee_q[addr_i[8:0]] <= wdata_i;
      else if (wr_i) reg_q[addr_i[7:0]] <= wdata_i;
      rdata_o <= rd_i ? (ee_i ? ee_q[addr_i[8:0]] : reg_q[addr_i[7:0]]) : ~rdata_o;
   end
endmodule : mem_model

// [framed_uart_command_engine_test.sv]
// Self-checking bench for the framed command engine.
// Assumes the design's map header and package; memory side is mem_model.
`timescale 1ns/1ps
`include "frame_cmd_map.svh"
module framed_uart_command_engine_test;
   import frame_cmd_pkg::*;
   typedef logic [7:0] q8_t[$];
   logic clk_i = 0, nrst_i = 0, rx_valid_i = 0, tx_ready_i = 0, multi_mode_i = 1;
   logic single_wire_i = 0, cycle_done_i = 0, rx_ready_o, tx_valid_o, mem_rd_o, mem_wr_o, mem_ee_o;
   logic dir_o, save_o, erase_o, cal_gain_o, cal_freq_o;
   logic [7:0] rx_data_i = 8'h00, dev_addr_i = 8'h4D, mem_rdata_i, tx_data_o, mem_wdata_o, p, s;
   logic [31:0] irms_i = 0, pact_i = 0, w;
   logic [15:0] vrms_i = 0, freq_i = 0, mem_addr_o;
   int err_count = 0, checks_done = 0, pc[4] = '{0, 0, 0, 0};
   q8_t rxq, pg, e;
   logic [7:0] cmds[4] = '{`CMD_SAVE, `CMD_ERASE, `CMD_CALG, `CMD_CALF};
   framed_uart_command_engine uut (.*);
   mem_model mem (.clk_i(clk_i), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rd_i(mem_rd_o),
                  .wr_i(mem_wr_o), .ee_i(mem_ee_o), .rdata_o(mem_rdata_i));
   initial forever #4 clk_i = ~clk_i;
   // Receiver stalls one cycle in four; collect bytes and pulses
   always @(posedge clk_i) begin
      tx_ready_i <= #1 1'($urandom_range(0, 3) != 0);
      if (tx_valid_o && tx_ready_i) rxq.push_back(tx_data_o);
      pc[0] += save_o; pc[1] += erase_o; pc[2] += cal_gain_o; pc[3] += cal_freq_o;
   end
   function automatic logic [7:0] iv(input int a);
      return 8'(a * 3 + 1);
   endfunction : iv
   // Data reply: acknowledge, count, data, byte sum
   function automatic q8_t rsp(input q8_t d);
      logic [7:0] t = 0;
      d.push_front(8'(d.size() + 3));
      d.push_front(`ACK_BYTE);
      foreach (d[i]) t += d[i];
      d.push_back(t);
      return d;
   endfunction : rsp
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // Whole frame out, bad adds to the checksum to corrupt it
   task automatic send(input q8_t f, input logic [7:0] bad = 0);
      logic [7:0] t = 0;
      int n;
      f.push_front(8'(f.size() + 3));
      f.push_front(`LEAD_BYTE);
      foreach (f[i]) t += f[i];
      f.push_back(t + bad);
      foreach (f[i]) begin
         rx_valid_i = 1;
         rx_data_i = f[i];
         n = 0;
         while (rx_ready_o !== 1'b1 && n < 2000) begin
            @(posedge clk_i); #1; n++;
         end
         if (n >= 2000) err_count++;   // Engine never took the byte
         @(posedge clk_i); #1;
      end
      rx_valid_i = 0;
   endtask : send
   task automatic expect_rsp(input string nm, input q8_t x);
      int n = 0;
      while (rxq.size() < x.size() && n < 2000) begin
         @(posedge clk_i); #1; n++;
      end
      repeat (30) @(posedge clk_i);
      #1;
      check(nm, rxq.size(), x.size());
      foreach (x[i]) check(nm, i < rxq.size() ? rxq[i] : 8'hxx, x[i]);
      rxq = {};
   endtask : expect_rsp
   task automatic final_report;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : final_report
   initial begin
      #400000;
      err_count++;
      final_report();
   end
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(53143));
      repeat (6) @(posedge clk_i);
      #1 nrst_i = 1;
      repeat (3) @(posedge clk_i);
      #1;
      send('{`CMD_PTR, 8'h00, 8'h10, `CMD_RD16});
      expect_rsp("rd16", rsp('{iv(17), iv(16)}));
      for (int k = 0; k < 3; k++) begin
         p = 8'($urandom_range(64, 240));
         w = $urandom;
         send('{`CMD_PTR, 8'h00, p, `CMD_WR32, w[31:24], w[23:16], w[15:8], w[7:0]});
         expect_rsp("wr32", '{`ACK_BYTE});
         send('{`CMD_PTR, 8'h00, p, `CMD_RD32, `CMD_RD16, `CMD_RDN, 8'h03});
         expect_rsp("rd", rsp('{w[31:24], w[23:16], w[15:8], w[7:0], w[15:8], w[7:0], w[7:0], w[15:8], w[23:16]}));
      end
      send('{`CMD_PTR, 8'h00, 8'h30, `CMD_WR16, 8'hAA, 8'hBB}, 8'h01);
      expect_rsp("csum", '{`CHECKSUM_ERROR_REPLY});
      send('{`CMD_PTR, 8'h00, 8'h30, `CMD_RD16});
      expect_rsp("nowr", rsp('{iv(49), iv(48)}));
      // Read budget: 48 bytes in one frame pass, one more is refused
      e = '{iv(3), iv(2), iv(1), iv(0)};
      for (int i = 0; i < 44; i++) e.push_back(iv(i));
      send('{`CMD_PTR, 8'h00, 8'h00, `CMD_RD32, `CMD_RDN, 8'h2C});
      expect_rsp("rd48", rsp(e));
      send('{`CMD_PTR, 8'h00, 8'h00, `CMD_RD32, `CMD_RDN, 8'h2D});
      expect_rsp("rd49", '{`NAK_BYTE});
      // Counted write inside the 64-byte budget, read back LSB first
      pg = {};
      repeat ($urandom_range(1, 8)) pg.push_back(8'($urandom));
      send({`CMD_PTR, 8'h00, 8'h20, `CMD_WRN, 8'(pg.size()), pg, `CMD_RDN, 8'(pg.size())});
      expect_rsp("wrn", rsp(pg));
      w = $urandom;
      send('{`CMD_PTR, 8'h00, 8'h40, `CMD_WR16, w[15:8], w[7:0], `CMD_RD16});
      expect_rsp("wr16", rsp('{w[15:8], w[7:0]}));
      send('{`CMD_PTR, 8'h01, 8'h00});
      expect_rsp("ptr", '{`NAK_BYTE});
      send('{`CMD_SEL, 8'h4D});
      expect_rsp("sel", '{`ACK_BYTE});
      check("dir", dir_o, 1);
      send('{`CMD_DESEL, 8'h4D});
      expect_rsp("desel", '{`ACK_BYTE});
      check("dir", dir_o, 0);
      multi_mode_i = 0;
      send('{`CMD_SEL, 8'h4D});
      expect_rsp("sel1", '{`ACK_BYTE});
      check("dir", dir_o, 0);
      foreach (cmds[k]) begin
         send('{cmds[k], 8'h4D});
         expect_rsp("pulse", '{`ACK_BYTE});
         check("pulse", pc[k], 1);
      end
      // Wrong device address: refused, no second save pulse
      send('{`CMD_SAVE, 8'h4C});
      expect_rsp("badaddr", '{`NAK_BYTE});
      check("nosave", pc[0], 1);
      pg = {};
      for (int i = 0; i < 16; i++) pg.push_back(8'($urandom));
      send({`CMD_PGWR, 8'h03, pg});
      expect_rsp("pgwr", '{`ACK_BYTE});
      send('{`CMD_PGRD, 8'h03});
      expect_rsp("pgrd", rsp(pg));
      {irms_i, vrms_i, pact_i, freq_i} = {$urandom, $urandom, $urandom};
      single_wire_i = 1;
      cycle_done_i = 1;
      @(posedge clk_i);
      #1 cycle_done_i = 0;
      e = '{`STREAM_LEAD_BYTE_FIRST, `STREAM_LEAD_BYTE_SECOND, `STREAM_LEAD_BYTE_THIRD};
      for (int k = 0; k < 12; k++) e.push_back(8'({freq_i, pact_i, vrms_i, irms_i} >> (8 * k)));
      s = 0;
      foreach (e[i]) s += e[i];
      e.push_back(s);
      expect_rsp("stream", e);
      final_report();
   end
endmodule : framed_uart_command_engine_test
